// *** rtl/usr_defs.svh ***
// Constants for the universal shift register block
`ifndef USR_DEFS_SVH
`define USR_DEFS_SVH

`define USR_ADDR_W 8
`define USR_ADDR_CTRL 8'h00
`define USR_ADDR_CMD 8'h04
`define USR_ADDR_STATUS 8'h08

`define USR_CTRL_SW_MODE 0
`define USR_CTRL_RST 1'b0

`define USR_ST_EMPTY 8
`define USR_ST_FULL 9
`define USR_ST_BUS_OE 10
`define USR_ST_SW_MODE 11
`define USR_ST_LEVEL_LSB 16

`define USR_RESP_OKAY 2'b00
`define USR_RESP_DECERR 2'b11

`define USR_SHREG_RST 8'h00
`define USR_FIFO_DEPTH 32
`define USR_CMD_BITS 12

`endif

// *** rtl/usr_pkg.sv ***
// Types shared by the universal shift register block
package usr_pkg;

   typedef enum logic [1:0] {
      MODE_HOLD = 2'b00,
      MODE_RIGHT = 2'b01,
      MODE_LEFT = 2'b10,
      MODE_LOAD = 2'b11
   } mode_t;

   typedef struct packed {
      mode_t mode;
      logic ser_left;
      logic ser_right;
      logic [7:0] data;
   } cmd_t;

endpackage

// *** rtl/usr_top.sv ***
// Universal 8-bit shift register with AXI4-Lite access and command FIFO
// Contract
// - Eight-bit register: shift right, left, load, hold
// - Changes only on shift clock rising edge
// - Master clear low forces all bits low
// - Master clear overrides modes and clock edges
// - Mode bits: 11 load, 01 right, 10 left, 00 hold
// - Load copies each bus line to same bit
// - Right shift: bit0 takes serial in, upward move
// - Left shift: bit7 takes serial in, downward move
// - Hold keeps contents regardless of clock
// - Either enable high releases all bus lines
// - Released bus never stops register activity
// - Both mode bits high also release bus
// - Bus lines are outputs and load inputs
// - Enabled, not loading: drive register onto bus
// - Bit0 and bit7 always on serial end outputs
//
// Design decisions made here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
`include "usr_defs.svh"

module usr_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 32
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   output logic [$clog2(DEPTH+1)-1:0] level
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic push;
   logic pop;

   assign in_ready = count_reg != CW'(DEPTH);
   assign out_valid = count_reg != '0;
   assign out_data = mem[rd_ptr_reg];
   assign level = count_reg;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_ff @(posedge aclk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // Explicit wrap keeps non power-of-two depths honest
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_ptr_reg <= '0;
      end else if (push) begin
         wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_ptr_reg <= '0;
      end else if (pop) begin
         rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_reg <= '0;
      end else if (push && !pop) begin
         count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
         count_reg <= count_reg - 1'b1;
      end
   end
endmodule

module usr_top
   import usr_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [`USR_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`USR_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic shift_clock,
   input wire logic master_clear_n,
   input wire logic mode_sel_bit0,
   input wire logic mode_sel_bit1,
   input wire logic ser_in_rightward,
   input wire logic ser_in_leftward,
   input wire logic bus_drive_en_n_a,
   input wire logic bus_drive_en_n_b,
   input wire logic [7:0] bus_in,
   output logic [7:0] bus_out,
   output logic bus_oe,
   output logic ser_end_out_first,
   output logic ser_end_out_last
);
   localparam int LW = $clog2(`USR_FIFO_DEPTH + 1);

   logic [7:0] shreg_reg;
   logic shift_clock_reg;
   logic bus_oe_reg;
   logic sw_mode_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic [`USR_ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;

   logic rise;
   logic step;
   cmd_t pin_cmd;
   cmd_t fifo_cmd;
   cmd_t eff_cmd;
   logic [`USR_CMD_BITS-1:0] fifo_out_data;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic [LW-1:0] fifo_level;
   logic [31:0] wmask;
   logic wr_pending;
   logic wr_is_cmd;
   logic wr_go;
   logic [31:0] status_word;

   // Shift clock is a plain input; its rising edge is found by sampling
   assign rise = shift_clock && !shift_clock_reg;

   always_ff @(posedge aclk) begin
      // Seeded high so a clock already high at reset release is no edge
      if (!aresetn) begin
         shift_clock_reg <= 1'b1;
      end else begin
         shift_clock_reg <= shift_clock;
      end
   end

   assign pin_cmd.mode = mode_t'({mode_sel_bit1, mode_sel_bit0});
   assign pin_cmd.ser_left = ser_in_leftward;
   assign pin_cmd.ser_right = ser_in_rightward;
   assign pin_cmd.data = bus_in;
   assign fifo_cmd = cmd_t'(fifo_out_data);

   // Software mode takes mode, serial bits and load data from the FIFO;
   // the shift clock still paces every step. An empty FIFO means hold.
   assign eff_cmd = sw_mode_reg ? fifo_cmd : pin_cmd;
   assign step = rise && master_clear_n
      && (!sw_mode_reg || fifo_out_valid);
   assign fifo_out_ready = sw_mode_reg && rise && master_clear_n;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shreg_reg <= `USR_SHREG_RST;
      end else if (!master_clear_n) begin
         shreg_reg <= `USR_SHREG_RST;
      end else if (step) begin
         unique case (eff_cmd.mode)
            MODE_HOLD: begin
               shreg_reg <= shreg_reg;
            end
            MODE_RIGHT: begin
               shreg_reg <= {shreg_reg[6:0], eff_cmd.ser_right};
            end
            MODE_LEFT: begin
               shreg_reg <= {eff_cmd.ser_left, shreg_reg[7:1]};
            end
            MODE_LOAD: begin
               shreg_reg <= eff_cmd.data;
            end
         endcase
      end
   end

   // Driver enable follows the pins one clock later; the register keeps
   // running whatever the enable, so only the pin direction changes.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bus_oe_reg <= 1'b0;
      end else begin
         bus_oe_reg <= !bus_drive_en_n_a && !bus_drive_en_n_b
            && !(mode_sel_bit0 && mode_sel_bit1);
      end
   end

   assign bus_out = shreg_reg;
   assign bus_oe = bus_oe_reg;
   assign ser_end_out_first = shreg_reg[0];
   assign ser_end_out_last = shreg_reg[7];

   usr_fifo #(
      .WIDTH(`USR_CMD_BITS),
      .DEPTH(`USR_FIFO_DEPTH)
   ) cmd_fifo (
      .aclk(aclk),
      .aresetn(aresetn),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(wdata_reg[`USR_CMD_BITS-1:0]),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data),
      .level(fifo_level)
   );

   genvar lane;
   generate
      for (lane = 0; lane < 4; lane++) begin : g_lane
         assign wmask[8*lane +: 8] = {8{s_axi_wstrb[lane]}};
      end
   endgenerate

   // Address and data are caught independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b1;
         awaddr_reg <= '0;
      end else if (s_axi_awvalid && awready_reg) begin
         awready_reg <= 1'b0;
         awaddr_reg <= s_axi_awaddr;
      end else if (bvalid_reg && s_axi_bready) begin
         awready_reg <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_reg <= 1'b1;
         wdata_reg <= '0;
      end else if (s_axi_wvalid && wready_reg) begin
         wready_reg <= 1'b0;
         wdata_reg <= s_axi_wdata & wmask;
      end else if (bvalid_reg && s_axi_bready) begin
         wready_reg <= 1'b1;
      end
   end

   assign wr_pending = !awready_reg && !wready_reg && !bvalid_reg;
   assign wr_is_cmd = awaddr_reg == `USR_ADDR_CMD;
   // A full FIFO holds the write response back, stalling the master
   assign fifo_in_valid = wr_pending && wr_is_cmd;
   assign wr_go = wr_pending && (!wr_is_cmd || fifo_in_ready);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `USR_RESP_OKAY;
      end else if (wr_go) begin
         bvalid_reg <= 1'b1;
         if (awaddr_reg == `USR_ADDR_CTRL || wr_is_cmd
               || awaddr_reg == `USR_ADDR_STATUS) begin
            bresp_reg <= `USR_RESP_OKAY;
         end else begin
            bresp_reg <= `USR_RESP_DECERR;
         end
      end else if (bvalid_reg && s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_mode_reg <= `USR_CTRL_RST;
      end else if (wr_go && awaddr_reg == `USR_ADDR_CTRL
            && s_axi_wstrb[0]) begin
         sw_mode_reg <= wdata_reg[`USR_CTRL_SW_MODE];
      end
   end

   always_comb begin
      status_word = '0;
      status_word[7:0] = shreg_reg;
      status_word[`USR_ST_EMPTY] = !fifo_out_valid;
      status_word[`USR_ST_FULL] = !fifo_in_ready;
      status_word[`USR_ST_BUS_OE] = bus_oe_reg;
      status_word[`USR_ST_SW_MODE] = sw_mode_reg;
      status_word[`USR_ST_LEVEL_LSB +: LW] = fifo_level;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rresp_reg <= `USR_RESP_OKAY;
         rdata_reg <= '0;
      end else if (s_axi_arvalid && arready_reg) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= `USR_RESP_OKAY;
         rdata_reg <= '0;
         if (s_axi_araddr == `USR_ADDR_CTRL) begin
            rdata_reg[`USR_CTRL_SW_MODE] <= sw_mode_reg;
         end else if (s_axi_araddr == `USR_ADDR_STATUS) begin
            rdata_reg <= status_word;
         end else if (s_axi_araddr != `USR_ADDR_CMD) begin
            rresp_reg <= `USR_RESP_DECERR;
         end
      end else if (rvalid_reg && s_axi_rready) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;
endmodule

// *** bench/usr_top_sva.sv ***
// Checker for the shift register pins of usr_top
`timescale 1ns/1ns
module usr_top_sva (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic shift_clock,
   input wire logic master_clear_n,
   input wire logic mode_sel_bit0,
   input wire logic mode_sel_bit1,
   input wire logic ser_in_rightward,
   input wire logic ser_in_leftward,
   input wire logic bus_drive_en_n_a,
   input wire logic bus_drive_en_n_b,
   input wire logic [7:0] bus_in,
   input wire logic [7:0] bus_out,
   input wire logic bus_oe,
   input wire logic ser_end_out_first,
   input wire logic ser_end_out_last
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [1:0] md;
   assign md = {mode_sel_bit1, mode_sel_bit0};
   // The edge detector restarts as if the clock were high after reset
   sequence edge_s;
      $rose(shift_clock) && $past(aresetn) && master_clear_n;
   endsequence
   load_copy_a: assert property (
      edge_s ##0 md == 2'h3 |=> bus_out == $past(bus_in))
      else $error("load copy wrong");
   right_shift_a: assert property (
      edge_s ##0 md == 2'h1 |=>
      bus_out == {$past(bus_out[6:0]), $past(ser_in_rightward)})
      else $error("right shift wrong");
   left_shift_a: assert property (
      edge_s ##0 md == 2'h2 |=>
      bus_out == {$past(ser_in_leftward), $past(bus_out[7:1])})
      else $error("left shift wrong");
   hold_keep_a: assert property (
      md == 2'h0 && master_clear_n |=> $stable(bus_out))
      else $error("hold changed register");
   no_edge_a: assert property (
      !$rose(shift_clock) && master_clear_n |=> $stable(bus_out))
      else $error("change without shift edge");
   clear_zero_a: assert property (
      !master_clear_n |=> bus_out == 8'h00 && !ser_end_out_first)
      else $error("clear did not zero");
   en_release_a: assert property (
      bus_drive_en_n_a || bus_drive_en_n_b |=> !bus_oe)
      else $error("bus driven while disabled");
   load_release_a: assert property (
      md == 2'h3 |=> !bus_oe)
      else $error("bus driven in load mode");
   bus_drive_a: assert property (
      !bus_drive_en_n_a && !bus_drive_en_n_b && md != 2'h3 |=> bus_oe)
      else $error("bus not driven");
   ser_ends_a: assert property (
      ser_end_out_first == bus_out[0] && ser_end_out_last == bus_out[7])
      else $error("serial ends wrong");
endmodule
bind usr_top usr_top_sva chk (.*);

// *** bench/bus_party.sv ***
// Outside party sharing the parallel bus with the device
`timescale 1ns/1ns
module bus_party (
   input wire logic aclk,
   input wire logic bus_oe,
   input wire logic [7:0] bus_out,
   input wire logic drive_en,
   input wire logic [7:0] drive_val,
   output logic [7:0] bus_in
);
   logic [7:0] last_reg = 8'h00;
   // Yields while the device drives; a floating bus keeps toggling
   assign bus_in = bus_oe ? bus_out
      : drive_en ? drive_val : ~last_reg;
   always_ff @(posedge aclk) begin
      last_reg <= bus_in;
   end
endmodule

// *** bench/tb.sv ***
// Testbench for usr_top
`timescale 1ns/1ns
`include "usr_defs.svh"
module tb;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, shift_clock;
   logic master_clear_n, mode_sel_bit0, mode_sel_bit1, bus_oe;
   logic ser_in_rightward, ser_in_leftward, bus_drive_en_n_a;
   logic bus_drive_en_n_b, ser_end_out_first, ser_end_out_last, drive_en;
   logic [7:0] s_axi_awaddr, s_axi_araddr, bus_in, bus_out, drive_val;
   logic [7:0] d, q;
   logic [31:0] s_axi_wdata, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r, m;
   int num_errors = 0;
   int compares = 0;
   usr_top dut (.*);
   bus_party party (.aclk(aclk), .bus_oe(bus_oe), .bus_out(bus_out),
      .drive_en(drive_en), .drive_val(drive_val), .bus_in(bus_in));
   always #5 aclk = ~aclk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] x);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= x;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      v = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   // High one cycle, low one cycle: the shortest legal shift clock
   task automatic pulse();
      @(posedge aclk) shift_clock <= 1'b1;
      @(posedge aclk) shift_clock <= 1'b0;
      @(posedge aclk);
      #1;
   endtask
   initial begin
      #200000;
      num_errors++;
      summarize();
   end
   initial begin
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, shift_clock, mode_sel_bit0} = '0;
      {mode_sel_bit1, ser_in_rightward, ser_in_leftward} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, drive_val, q} = '0;
      {master_clear_n, bus_drive_en_n_a, bus_drive_en_n_b, drive_en} = '1;
      s_axi_wstrb = 4'hf;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk) bus_drive_en_n_b <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         m = 2'(3 - i % 4);
         d = 8'h5a ^ 8'(i);
         @(posedge aclk);
         {mode_sel_bit1, mode_sel_bit0} <= m;
         ser_in_rightward <= i[0];
         ser_in_leftward <= i[1];
         bus_drive_en_n_a <= i[2];
         drive_val <= d;
         pulse();
         case (m)
            2'h3: q = d;
            2'h1: q = {q[6:0], i[0]};
            2'h2: q = {i[1], q[7:1]};
            default: q = q;
         endcase
         check(bus_out, q);
         check({ser_end_out_last, ser_end_out_first}, {q[7], q[0]});
         check(bus_oe, !i[2] && m != 2'h3);
      end
      @(posedge aclk) master_clear_n <= 1'b0;
      {mode_sel_bit1, mode_sel_bit0} <= 2'h3;
      pulse();
      check(bus_out, 8'h00);
      @(posedge aclk) master_clear_n <= 1'b1;
      rd(`USR_ADDR_STATUS);
      check(v, 32'h0000_0100);
      wr(`USR_ADDR_CTRL, 32'h1);
      check(r, `USR_RESP_OKAY);
      rd(`USR_ADDR_CTRL);
      check(v, 32'h1);
      rd(`USR_ADDR_CMD);
      check(v, 32'h0);
      wr(8'h0c, 32'h1);
      check(r, `USR_RESP_DECERR);
      rd(8'h0c);
      check({v[1:0], r}, {2'h0, `USR_RESP_DECERR});
      bus_drive_en_n_a <= 1'b0;
      for (int k = 1; k <= 32; k++) wr(`USR_ADDR_CMD, 32'h0c00 | k);
      rd(`USR_ADDR_STATUS);
      check(v & 32'h003f_0300, 32'h0020_0200);
      // The extra command must wait until a shift step frees a slot
      fork
         wr(`USR_ADDR_CMD, 32'h0c21);
         begin
            repeat (20) @(posedge aclk);
            check(s_axi_bvalid, 1'b0);
            for (int k = 1; k <= 33; k++) begin
               @(posedge aclk) drive_val <= 8'(k);
               pulse();
               check(bus_out, 8'(k));
            end
         end
      join
      rd(`USR_ADDR_STATUS);
      check(v, 32'h0000_0921);
      wr(`USR_ADDR_CTRL, 32'h0);
      summarize();
   end
endmodule
